//--- rtl/csl_cfg.svh
// Constants for the configuration sequencer and its test-port loader
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH
`define CSL_CLK_PERIOD_NS 8
`define CSL_T_POR_MS 2.0
`define CSL_CLEAR_CYCLES 64
`define CSL_ABORT_CYCLES 8
`define CSL_CNT_W 20
`define CSL_CNT_ONE 20'h00001
`define CSL_IR_W 5
`define CSL_IR_CFG_LOAD 5'h05
`define CSL_IR_STARTUP 5'h0c
`define CSL_IR_READBACK 5'h04
`define CSL_IR_BYPASS 5'h1f
`define CSL_IR_CAPTURE 5'h01
`define CSL_WORD_W 32
`define CSL_BIT_LAST 5'h1f
`define CSL_BIT_ONE 5'h01
`define CSL_SYNC_WORD 32'h5a5ac3c3
`define CSL_MODE_TAP_A 3'h5
`define CSL_MODE_TAP_B 3'h1
`define CSL_N_DLL 8
`define CSL_STAGE_ONE 3'h1
`define CSL_DONE_STAGE 3'h1
`define CSL_GTS_STAGE 3'h2
`define CSL_GWE_STAGE 3'h3
`endif

//--- rtl/csl_pkg.sv
// Types shared by the configuration sequencer
package csl_pkg;
  typedef enum logic [2:0] {
    SEQ_POR = 3'h0, SEQ_CLEAR = 3'h1, SEQ_INIT_WAIT = 3'h3,
    SEQ_LOAD = 3'h2, SEQ_STARTUP = 3'h6, SEQ_DONE = 3'h7
  } csl_seq_t;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SHIFT_DR = 4'h6, TAP_EXIT1_DR = 4'h7, TAP_UPD_DR = 4'h5, TAP_PAUSE_DR = 4'h4,
    TAP_EXIT2_DR = 4'hc, TAP_SEL_IR = 4'hb, TAP_CAP_IR = 4'ha, TAP_SHIFT_IR = 4'he,
    TAP_EXIT1_IR = 4'hf, TAP_UPD_IR = 4'hd, TAP_PAUSE_IR = 4'h8, TAP_EXIT2_IR = 4'h9
  } csl_tap_t;
  // Start-up options, static while a start-up runs
  typedef struct packed {
    logic sync_done;
    logic lock_wait;
    logic lock_all;
    logic [2:0] lock_stage;
    logic [7:0] lock_mask;
  } csl_opts_t;
  typedef struct packed {
    logic output_tristate;
    logic set_reset;
    logic write_en;
  } csl_glob_t;
  // What enters the main clock domain through the synchronizer; the packet word in word_hold_reg is read directly
  typedef struct packed {
    logic [7:0] dll_locked;
    logic [2:0] mode;
    logic done_in;
    logic init_in;
    logic restart_n;
    logic word_tgl;
    logic step_tgl;
    logic abort_tgl;
    logic rb_req_tgl;
  } csl_async_t;
endpackage : csl_pkg

//--- rtl/csl_loader.sv
// Configuration sequencer with test-access-port loading and start-up control
`timescale 1ns/1ns
`include "csl_cfg.svh"
// Overview of operation
// RULE_01: With the load instruction active, bits on TDI become 32-bit configuration packets.
// RULE_02: Host loads the load instruction, shifts the bitstream in Shift-DR, returns to idle.
// RULE_03: Host loads the start-up instruction and clocks TCK in Shift-DR until done.
// RULE_04: The test port takes configuration and readback whatever the mode pins say.
// RULE_05: Mode pins reading 101 or 001 select test-port configuration mode.
// RULE_06: Phases run in order: clear memory, load data, then start-up.
// RULE_07: Configuration starts after power-up unless held off, and on every restart.
// RULE_08: Init line goes High after clearing; DONE goes High after start-up completes. Here DONE rises at DONE_STAGE, before the later release stages.
// RULE_09: Power-on delay lasts at most 2.0 ms before clearing begins.
// RULE_10: Init line is pulled Low for the whole memory-clear phase.
// RULE_11: Init held Low from outside keeps the sequencer out of the load phase.
// RULE_12: Readback returns configuration data and current storage element contents.
// RULE_13: By default the output tri-state releases one configuration clock after DONE.
// RULE_14: One configuration clock later set/reset and write-enable release together.
// RULE_15: Release order is settable and may wait for all DONE lines to be High.
// RULE_16: Start-up may pause at a chosen stage until any or all selected loops lock.
// RULE_17: With lock waiting enabled DONE stays Low until the loop reports lock. Here DONE is held only when opts.lock_stage is 0.
// RULE_18: Switching between load and readback mid-packet aborts, holds busy, needs resync.
// RULE_19: Restart in any phase abandons it, pulls init Low and clears again.
module csl_loader #(
  parameter int POR_CYCLES = int'($floor(`CSL_T_POR_MS * 1.0e6 / `CSL_CLK_PERIOD_NS)),
  parameter int CLEAR_CYCLES = `CSL_CLEAR_CYCLES,
  parameter int ABORT_CYCLES = `CSL_ABORT_CYCLES,
  parameter logic [31:0] SYNC_WORD = `CSL_SYNC_WORD,
  parameter logic [2:0] DONE_STAGE = `CSL_DONE_STAGE,
  parameter logic [2:0] GTS_STAGE = `CSL_GTS_STAGE,
  parameter logic [2:0] GWE_STAGE = `CSL_GWE_STAGE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  input wire logic [2:0] mode_select,
  input wire logic restart_n,
  input wire logic init_in,
  output logic init_out,
  output logic init_oe,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  input wire logic [7:0] dll_locked,
  input wire csl_pkg::csl_opts_t opts,
  output logic [31:0] cfg_word,
  output logic cfg_word_valid,
  input wire logic [31:0] rb_data,
  output logic rb_req,
  output logic busy,
  output logic done,
  output logic tap_mode,
  output csl_pkg::csl_glob_t globals,
  output csl_pkg::csl_seq_t phase
);

  function automatic csl_pkg::csl_tap_t tap_step(input csl_pkg::csl_tap_t s, input logic m);
    case (s)
      csl_pkg::TAP_RESET: tap_step = m ? csl_pkg::TAP_RESET : csl_pkg::TAP_IDLE;
      csl_pkg::TAP_IDLE: tap_step = m ? csl_pkg::TAP_SEL_DR : csl_pkg::TAP_IDLE;
      csl_pkg::TAP_SEL_DR: tap_step = m ? csl_pkg::TAP_SEL_IR : csl_pkg::TAP_CAP_DR;
      csl_pkg::TAP_CAP_DR: tap_step = m ? csl_pkg::TAP_EXIT1_DR : csl_pkg::TAP_SHIFT_DR;
      csl_pkg::TAP_SHIFT_DR: tap_step = m ? csl_pkg::TAP_EXIT1_DR : csl_pkg::TAP_SHIFT_DR;
      csl_pkg::TAP_EXIT1_DR: tap_step = m ? csl_pkg::TAP_UPD_DR : csl_pkg::TAP_PAUSE_DR;
      csl_pkg::TAP_PAUSE_DR: tap_step = m ? csl_pkg::TAP_EXIT2_DR : csl_pkg::TAP_PAUSE_DR;
      csl_pkg::TAP_EXIT2_DR: tap_step = m ? csl_pkg::TAP_UPD_DR : csl_pkg::TAP_SHIFT_DR;
      csl_pkg::TAP_UPD_DR: tap_step = m ? csl_pkg::TAP_SEL_DR : csl_pkg::TAP_IDLE;
      csl_pkg::TAP_SEL_IR: tap_step = m ? csl_pkg::TAP_RESET : csl_pkg::TAP_CAP_IR;
      csl_pkg::TAP_CAP_IR: tap_step = m ? csl_pkg::TAP_EXIT1_IR : csl_pkg::TAP_SHIFT_IR;
      csl_pkg::TAP_SHIFT_IR: tap_step = m ? csl_pkg::TAP_EXIT1_IR : csl_pkg::TAP_SHIFT_IR;
      csl_pkg::TAP_EXIT1_IR: tap_step = m ? csl_pkg::TAP_UPD_IR : csl_pkg::TAP_PAUSE_IR;
      csl_pkg::TAP_PAUSE_IR: tap_step = m ? csl_pkg::TAP_EXIT2_IR : csl_pkg::TAP_PAUSE_IR;
      csl_pkg::TAP_EXIT2_IR: tap_step = m ? csl_pkg::TAP_UPD_IR : csl_pkg::TAP_SHIFT_IR;
      csl_pkg::TAP_UPD_IR: tap_step = m ? csl_pkg::TAP_SEL_DR : csl_pkg::TAP_IDLE;
      default: tap_step = csl_pkg::TAP_RESET;
    endcase
  endfunction : tap_step

  function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b,
                                      input logic [2:0] c);
    logic [2:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction : max3

  ////////////////////////////////////////////////////////////////////////////////
  // Test access port, on the link clock

  csl_pkg::csl_tap_t tap_reg;
  logic [2:0] trst_sync_reg;
  logic [`CSL_IR_W-1:0] ir_reg;
  logic [`CSL_IR_W-1:0] ir_sh_reg;
  logic [31:0] dr_sh_reg;
  logic [31:0] word_hold_reg;
  logic [31:0] rb_buf_reg;
  logic [4:0] bit_cnt_reg;
  logic bypass_reg;
  logic tdo_reg;
  logic word_tgl_reg;
  logic step_tgl_reg;
  logic abort_tgl_reg;
  logic rb_req_tgl_reg;
  logic dir_rb_reg;
  logic active_reg;
  logic [2:0] ack_sync_reg;
  logic ack_seen_reg;
  logic [31:0] rb_hold_reg;
  logic ack_tgl_reg;

  wire logic tck_rst = trst_sync_reg[2];
  wire logic in_shift_dr = (tap_reg == csl_pkg::TAP_SHIFT_DR);
  // RULE_04: decoded in every mode
  wire logic ir_load = (ir_reg == `CSL_IR_CFG_LOAD);
  wire logic ir_rb = (ir_reg == `CSL_IR_READBACK);
  wire logic ir_start = (ir_reg == `CSL_IR_STARTUP);
  wire logic word_end = (bit_cnt_reg == `CSL_BIT_LAST);
  wire logic shift_load = in_shift_dr && ir_load;
  wire logic shift_rb = in_shift_dr && ir_rb;
  wire logic cap_rb = (tap_reg == csl_pkg::TAP_CAP_DR) && ir_rb;
  wire logic upd_ir = (tap_reg == csl_pkg::TAP_UPD_IR);
  wire logic new_is_data = (ir_sh_reg == `CSL_IR_CFG_LOAD) || (ir_sh_reg == `CSL_IR_READBACK);
  wire logic new_dir_rb = (ir_sh_reg == `CSL_IR_READBACK);
  // RULE_18: direction change while a transfer is active, mid-packet or not
  wire logic abort_now = upd_ir && new_is_data && active_reg && (new_dir_rb != dir_rb_reg);
  wire logic ack_ev = (ack_sync_reg[1] == ack_sync_reg[2]) && (ack_sync_reg[2] != ack_seen_reg);
  wire logic [31:0] dr_in = {dr_sh_reg[30:0], tdi};
  wire logic tdo_next = (tap_reg == csl_pkg::TAP_SHIFT_IR) ? ir_sh_reg[0] :
                        shift_rb ? dr_sh_reg[31] : bypass_reg;

  always_ff @(posedge tck) begin
    trst_sync_reg <= {trst_sync_reg[1:0], reset};
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      tap_reg <= csl_pkg::TAP_RESET;
      ir_reg <= `CSL_IR_BYPASS;
    end else begin
      tap_reg <= tap_step(tap_reg, tms);
      if (tap_reg == csl_pkg::TAP_RESET) ir_reg <= `CSL_IR_BYPASS;
      else if (upd_ir) ir_reg <= ir_sh_reg;
    end
  end

  always_ff @(posedge tck) begin
    if (tap_reg == csl_pkg::TAP_CAP_IR) ir_sh_reg <= `CSL_IR_CAPTURE;
    else if (tap_reg == csl_pkg::TAP_SHIFT_IR) ir_sh_reg <= {tdi, ir_sh_reg[`CSL_IR_W-1:1]};
    bypass_reg <= in_shift_dr && tdi;
    tdo_reg <= tdo_next;
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bit_cnt_reg <= '0;
      word_tgl_reg <= 1'b0;
      step_tgl_reg <= 1'b0;
      abort_tgl_reg <= 1'b0;
      rb_req_tgl_reg <= 1'b0;
      dir_rb_reg <= 1'b0;
      active_reg <= 1'b0;
      ack_sync_reg <= '0;
      ack_seen_reg <= 1'b0;
      rb_buf_reg <= '0;
      dr_sh_reg <= '0;
      word_hold_reg <= '0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
      if (ack_ev) begin
        ack_seen_reg <= ack_sync_reg[2];
        rb_buf_reg <= rb_hold_reg;
      end
      // RULE_01: assemble packets from TDI
      if (shift_load) begin
        dr_sh_reg <= dr_in;
        bit_cnt_reg <= bit_cnt_reg + `CSL_BIT_ONE;
        active_reg <= 1'b1;
        dir_rb_reg <= 1'b0;
        if (word_end) begin
          word_hold_reg <= dr_in;
          word_tgl_reg <= ~word_tgl_reg;
        end
      // RULE_12: readback words shift out on TDO
      end else if (cap_rb) begin
        dr_sh_reg <= rb_buf_reg;
        bit_cnt_reg <= '0;
        rb_req_tgl_reg <= ~rb_req_tgl_reg;
        active_reg <= 1'b1;
        dir_rb_reg <= 1'b1;
      end else if (shift_rb) begin
        dr_sh_reg <= word_end ? rb_buf_reg : {dr_sh_reg[30:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + `CSL_BIT_ONE;
        if (word_end) rb_req_tgl_reg <= ~rb_req_tgl_reg;
      end
      // RULE_03: each start-up clock is one step
      if (in_shift_dr && ir_start) step_tgl_reg <= ~step_tgl_reg;
      if (abort_now) begin
        abort_tgl_reg <= ~abort_tgl_reg;
        bit_cnt_reg <= '0;
        active_reg <= 1'b0;
      end else if (upd_ir && !new_is_data) begin
        active_reg <= 1'b0;
        bit_cnt_reg <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing into the main clock

  csl_pkg::csl_async_t as_raw;
  csl_pkg::csl_async_t s1_reg;
  csl_pkg::csl_async_t s2_reg;
  csl_pkg::csl_async_t s3_reg;
  csl_pkg::csl_async_t flt_reg;
  csl_pkg::csl_async_t prev_reg;
  csl_pkg::csl_async_t flt_next;

  assign as_raw = '{dll_locked: dll_locked, mode: mode_select, done_in: done_in,
                    init_in: init_in, restart_n: restart_n, word_tgl: word_tgl_reg,
                    step_tgl: step_tgl_reg, abort_tgl: abort_tgl_reg,
                    rb_req_tgl: rb_req_tgl_reg};
  // A rise counts once the last two stages agree; a fall counts as soon as s2_reg drops
  assign flt_next = (s2_reg & s3_reg) | (flt_reg & ~(s2_reg ^ s3_reg));

  always_ff @(posedge clk) begin
    s1_reg <= as_raw;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (reset) begin
      flt_reg <= '{restart_n: 1'b1, default: '0};
      prev_reg <= '{restart_n: 1'b1, default: '0};
    end else begin
      flt_reg <= flt_next;
      prev_reg <= flt_reg;
    end
  end

  wire logic word_ev = flt_reg.word_tgl ^ prev_reg.word_tgl;
  wire logic step_ev = flt_reg.step_tgl ^ prev_reg.step_tgl;
  wire logic abort_ev = flt_reg.abort_tgl ^ prev_reg.abort_tgl;
  wire logic rb_ev = flt_reg.rb_req_tgl ^ prev_reg.rb_req_tgl;
  wire logic restart = !flt_reg.restart_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  csl_pkg::csl_seq_t seq_reg;
  csl_pkg::csl_seq_t seq_next;
  logic [`CSL_CNT_W-1:0] cnt_reg;
  logic [`CSL_CNT_W-1:0] abort_cnt_reg;
  logic [2:0] stage_reg;
  logic synced_reg;
  logic [31:0] cfg_word_reg;
  logic cfg_valid_reg;
  logic rb_req_reg;
  logic busy_reg;
  logic done_reg;
  logic tap_mode_reg;
  logic init_oe_reg;
  logic done_oe_reg;
  csl_pkg::csl_glob_t glob_reg;

  wire logic [`CSL_CNT_W-1:0] por_last = `CSL_CNT_W'(POR_CYCLES - 1);
  wire logic [`CSL_CNT_W-1:0] clear_last = `CSL_CNT_W'(CLEAR_CYCLES - 1);
  wire logic [2:0] last_stage = max3(DONE_STAGE, GTS_STAGE, GWE_STAGE);
  // RULE_16: any or all of the selected loops
  wire logic [7:0] lk_mask = opts.lock_mask;
  wire logic lock_ok = opts.lock_all ? &(flt_reg.dll_locked | ~lk_mask)
                                     : |(flt_reg.dll_locked & lk_mask);
  // RULE_17: lock wait blocks the step out of opts.lock_stage, which raises DONE only when that stage is 0
  wire logic hold_lock = opts.lock_wait && (stage_reg == opts.lock_stage) && !lock_ok;
  // RULE_15: all devices' DONE lines gate the releases
  wire logic hold_done = opts.sync_done && (stage_reg >= DONE_STAGE) && !flt_reg.done_in;
  wire logic advance = (seq_reg == csl_pkg::SEQ_STARTUP) && step_ev && !hold_lock && !hold_done;
  wire logic [2:0] stage_next = advance ? stage_reg + `CSL_STAGE_ONE : stage_reg;
  wire logic is_sync = (word_hold_reg == SYNC_WORD);
  // RULE_05: test-port boot mode decode
  wire logic tap_mode_next = (flt_reg.mode == `CSL_MODE_TAP_A) ||
                             (flt_reg.mode == `CSL_MODE_TAP_B);

  // RULE_06: phase order
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      // RULE_09: power-on delay
      csl_pkg::SEQ_POR: if (cnt_reg == por_last) seq_next = csl_pkg::SEQ_CLEAR;
      csl_pkg::SEQ_CLEAR: if (cnt_reg == clear_last) seq_next = csl_pkg::SEQ_INIT_WAIT;
      // RULE_11: init held Low delays loading
      csl_pkg::SEQ_INIT_WAIT: if (flt_reg.init_in) seq_next = csl_pkg::SEQ_LOAD;
      csl_pkg::SEQ_LOAD: if (step_ev) seq_next = csl_pkg::SEQ_STARTUP;
      csl_pkg::SEQ_STARTUP: if (stage_next >= last_stage) seq_next = csl_pkg::SEQ_DONE;
      csl_pkg::SEQ_DONE: seq_next = csl_pkg::SEQ_DONE;
      default: seq_next = csl_pkg::SEQ_POR;
    endcase
    // RULE_07: restart starts configuration over
    // RULE_19: any phase is abandoned on restart
    if (restart) seq_next = csl_pkg::SEQ_CLEAR;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_reg <= csl_pkg::SEQ_POR;
      cnt_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      cnt_reg <= (seq_next != seq_reg || restart) ? '0 : cnt_reg + `CSL_CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || restart) begin
      stage_reg <= '0;
      done_reg <= 1'b0;
      glob_reg <= '{output_tristate: 1'b1, set_reset: 1'b1, write_en: 1'b0};
    end else begin
      stage_reg <= stage_next;
      // RULE_08: DONE rises on the step into DONE_STAGE, before the tri-state and write-enable releases
      done_reg <= (stage_next >= DONE_STAGE) && (seq_reg == csl_pkg::SEQ_STARTUP) || done_reg;
      // RULE_13: tri-state release stage
      if (stage_next >= GTS_STAGE) glob_reg.output_tristate <= 1'b0;
      // RULE_14: set/reset and write-enable together
      if (stage_next >= GWE_STAGE) begin
        glob_reg.set_reset <= 1'b0;
        glob_reg.write_en <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      synced_reg <= 1'b0;
      abort_cnt_reg <= '0;
      busy_reg <= 1'b0;
      cfg_word_reg <= '0;
      cfg_valid_reg <= 1'b0;
      rb_hold_reg <= '0;
      ack_tgl_reg <= 1'b0;
      rb_req_reg <= 1'b0;
      tap_mode_reg <= 1'b0;
      init_oe_reg <= 1'b1;
      done_oe_reg <= 1'b1;
    end else begin
      tap_mode_reg <= tap_mode_next;
      // RULE_10: init pulled Low until clearing ends
      init_oe_reg <= (seq_next == csl_pkg::SEQ_POR) || (seq_next == csl_pkg::SEQ_CLEAR);
      done_oe_reg <= !done_reg;
      cfg_valid_reg <= 1'b0;
      rb_req_reg <= rb_ev;
      if (rb_ev) begin
        rb_hold_reg <= rb_data;
        ack_tgl_reg <= ~ack_tgl_reg;
      end
      // RULE_18: abort drops alignment and holds busy
      if (abort_ev || restart) begin
        synced_reg <= 1'b0;
        abort_cnt_reg <= abort_ev ? `CSL_CNT_W'(ABORT_CYCLES) : '0;
        busy_reg <= abort_ev;
      end else if (busy_reg) begin
        abort_cnt_reg <= abort_cnt_reg - `CSL_CNT_ONE;
        busy_reg <= (abort_cnt_reg != `CSL_CNT_ONE);
      end else if (word_ev && seq_reg == csl_pkg::SEQ_LOAD) begin
        // RULE_01: aligned packets reach the configuration bus
        if (!synced_reg) synced_reg <= is_sync;
        else begin
          cfg_word_reg <= word_hold_reg;
          cfg_valid_reg <= 1'b1;
        end
      end
    end
  end

  assign tdo = tdo_reg;
  assign init_out = 1'b0;
  assign init_oe = init_oe_reg;
  assign done_out = 1'b0;
  assign done_oe = done_oe_reg;
  assign cfg_word = cfg_word_reg;
  assign cfg_word_valid = cfg_valid_reg;
  assign rb_req = rb_req_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign tap_mode = tap_mode_reg;
  assign globals = glob_reg;
  assign phase = seq_reg;

endmodule : csl_loader

//--- verification/csl_loader_assertions.sv
// Port-level checks for the configuration sequencer
`timescale 1ns/1ns
module csl_loader_assertions #(
  parameter int POR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] mode_select,
  input wire logic restart_n,
  input wire logic init_in,
  input wire logic init_oe,
  input wire logic done_oe,
  input wire logic [7:0] dll_locked,
  input wire csl_pkg::csl_opts_t opts,
  input wire logic cfg_word_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic tap_mode,
  input wire csl_pkg::csl_glob_t globals,
  input wire csl_pkg::csl_seq_t phase
);
  int por_cnt;
  csl_pkg::csl_seq_t pred;
  wire tap_pins = (mode_select == 3'h5) || (mode_select == 3'h1);
  // Only predecessor allowed for each phase from SEQ_INIT_WAIT to SEQ_DONE
  assign pred = (phase == csl_pkg::SEQ_INIT_WAIT) ? csl_pkg::SEQ_CLEAR :
    (phase == csl_pkg::SEQ_LOAD) ? csl_pkg::SEQ_INIT_WAIT :
    (phase == csl_pkg::SEQ_STARTUP) ? csl_pkg::SEQ_LOAD :
    (phase == csl_pkg::SEQ_DONE) ? csl_pkg::SEQ_STARTUP : csl_pkg::SEQ_POR;
  always_ff @(posedge clk) begin
    if (reset || phase != csl_pkg::SEQ_POR) begin
      por_cnt <= 0;
    end else begin
      por_cnt <= por_cnt + 1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_tap_pins;
    tap_pins [*6];
  endsequence
  sequence s_other_pins;
    !tap_pins [*6];
  endsequence
  sequence s_restart;
    !restart_n [*5];
  endsequence
  chk_tap_mode_on: assert property (s_tap_pins |-> tap_mode)
    else $error("tap mode missing");
  chk_tap_mode_off: assert property (s_other_pins |-> !tap_mode)
    else $error("tap mode set wrongly");
  chk_phase_order: assert property ($changed(phase) && pred != csl_pkg::SEQ_POR |->
    $past(phase) == pred)
    else $error("phase out of order");
  chk_clear_init: assert property (phase == csl_pkg::SEQ_CLEAR |-> init_oe)
    else $error("init released in clear");
  chk_init_hold: assert property (phase == csl_pkg::SEQ_LOAD &&
    $past(phase) == csl_pkg::SEQ_INIT_WAIT |-> $past(init_in, 2))
    else $error("load entered with init low");
  chk_done_rise: assert property ($rose(done) |->
    phase == csl_pkg::SEQ_STARTUP && !init_oe ##1 !done_oe)
    else $error("done raised wrongly");
  chk_tristate_late: assert property ($fell(globals.output_tristate) |->
    done && $past(done, 4))
    else $error("tristate released early");
  chk_setreset_pair: assert property ($fell(globals.set_reset) |->
    $rose(globals.write_en) && $past(globals.output_tristate, 4) == 1'b0)
    else $error("set reset release wrong");
  chk_lock_done: assert property ($rose(done) && opts.lock_wait && !opts.lock_all &&
    opts.lock_stage == 3'h0 |-> (dll_locked & opts.lock_mask) != 8'h00)
    else $error("done without lock");
  chk_restart_clear: assert property (s_restart |=>
    phase == csl_pkg::SEQ_CLEAR && init_oe && !done)
    else $error("restart ignored");
  chk_word_gate: assert property (cfg_word_valid |->
    phase == csl_pkg::SEQ_LOAD && !busy)
    else $error("word outside load");
  chk_abort_len: assert property ($rose(busy) |-> busy [*8] ##1 !busy)
    else $error("busy length wrong");
  chk_por_len: assert property (phase == csl_pkg::SEQ_POR |-> por_cnt < POR_CYCLES)
    else $error("power-on delay too long");
endmodule : csl_loader_assertions

//--- verification/csl_tap_host.sv
// Test-port host model; its clock runs only during an operation
`timescale 1ns/1ns
module csl_tap_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////
  // One 48 ns link clock; tdo launched by this rise is taken before the fall
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #23;
    tck = 1'b1;
    #25;
    q = tdo;
    tck = 1'b0;
    tdi = ~d;
  endtask : step
  task automatic tap_reset();
    logic q;
    for (int i = 0; i < 7; i++) step(i < 6, 1'b0, q);
  endtask : tap_reset
  task automatic load_ir(input logic [4:0] code);
    logic q;
    for (int i = 0; i < 4; i++) step(i < 2, 1'b0, q);
    for (int i = 0; i < 5; i++) step(i == 4, code[i], q);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : load_ir
  task automatic shift_dr(input logic [127:0] d, input int n, output logic [31:0] rd);
    logic q;
    rd = 32'h0;
    for (int i = 0; i < 3; i++) step(i == 0, 1'b0, q);
    for (int i = n - 1; i >= 0; i--) begin
      step(i == 0, d[i], q);
      rd = {rd[30:0], q};
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : shift_dr
endmodule : csl_tap_host

//--- verification/tb_top.sv
// Self-checking bench for the configuration sequencer
`timescale 1ns/1ns
`include "csl_cfg.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] mode_select = 3'h5;
  logic restart_n = 1'b1;
  logic hold_init = 1'b1;
  logic hold_done = 1'b0;
  logic [7:0] dll_locked = 8'h00;
  csl_pkg::csl_opts_t opts = '0;
  logic [31:0] rb_data = 32'h0;
  logic tck, tms, tdi, tdo, init_oe, done_oe, word_valid, rb_req, busy, done, tap_mode;
  logic init_out, done_out;
  logic [31:0] cfg_word;
  csl_pkg::csl_glob_t globals;
  csl_pkg::csl_seq_t phase;
  logic [31:0] words[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int rb_reqs = 0;
  int busy_cnt = 0;
  wire init_in = !hold_init && (init_oe ? init_out : 1'b1);
  wire done_in = !hold_done && (done_oe ? done_out : 1'b1);
  always #4 clk = ~clk;
  csl_tap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  csl_loader #(.POR_CYCLES(20), .CLEAR_CYCLES(8)) uut (
    .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .mode_select(mode_select), .restart_n(restart_n), .init_in(init_in), .init_out(init_out),
    .init_oe(init_oe), .done_in(done_in), .done_out(done_out), .done_oe(done_oe),
    .dll_locked(dll_locked), .opts(opts), .cfg_word(cfg_word), .cfg_word_valid(word_valid),
    .rb_data(rb_data), .rb_req(rb_req), .busy(busy), .done(done), .tap_mode(tap_mode),
    .globals(globals), .phase(phase));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (word_valid === 1'b1) words.push_back(cfg_word);
    if (rb_req === 1'b1) rb_reqs <= rb_reqs + 1;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wait_phase(input csl_pkg::csl_seq_t p);
    for (int i = 0; i < 500 && phase !== p; i++) @(negedge clk);
    check(32'(phase), 32'(p), "phase");
  endtask : wait_phase
  // Unsynced word first, which must be dropped
  task automatic send_words();
    logic [31:0] w[3];
    logic [31:0] rd;
    int n0;
    foreach (w[i]) w[i] = $urandom();
    n0 = words.size();
    host.load_ir(`CSL_IR_CFG_LOAD);
    host.shift_dr({96'h0, ~`CSL_SYNC_WORD}, 32, rd);
    host.shift_dr({`CSL_SYNC_WORD, w[0], w[1], w[2]}, 128, rd);
    repeat (12) @(negedge clk);
    check(words.size(), n0 + 3, "word count");
    for (int i = 0; i < 3; i++) check(words[n0 + i], w[i], "word");
  endtask : send_words
  task automatic startup();
    logic [31:0] rd;
    host.load_ir(`CSL_IR_STARTUP);
    host.shift_dr(128'h0, 8, rd);
    repeat (12) @(negedge clk);
  endtask : startup
  task automatic check_ready();
    check(32'(phase), 32'(csl_pkg::SEQ_DONE), "end phase");
    check({done, init_oe, done_oe, globals}, 6'b100001, "status");
  endtask : check_ready
  task automatic run_held(input csl_pkg::csl_opts_t o, input logic [7:0] lock);
    @(posedge clk);
    restart_n <= 1'b0;
    opts <= o;
    dll_locked <= ~o.lock_mask;
    hold_done <= o.sync_done;
    repeat (10) @(negedge clk);
    check({phase, init_oe, done, globals}, {csl_pkg::SEQ_CLEAR, 5'b10110}, "restart");
    @(posedge clk);
    restart_n <= 1'b1;
    wait_phase(csl_pkg::SEQ_LOAD);
    send_words();
    startup();
    check({phase, done, globals}, {csl_pkg::SEQ_STARTUP, o.sync_done, 3'b110}, "held");
    @(posedge clk);
    dll_locked <= lock;
    hold_done <= 1'b0;
    startup();
    check_ready();
  endtask : run_held
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    csl_pkg::csl_opts_t o;
    logic [31:0] rd;
    void'($urandom(32'h821ddeb2));
    host.tap_reset();
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    host.tap_reset();
    wait_phase(csl_pkg::SEQ_INIT_WAIT);
    repeat (30) @(negedge clk);
    check(32'(phase), 32'(csl_pkg::SEQ_INIT_WAIT), "held init");
    @(posedge clk);
    hold_init <= 1'b0;
    wait_phase(csl_pkg::SEQ_LOAD);
    $display("test power-up done");
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      mode_select <= 3'(m);
      repeat (8) @(negedge clk);
      check(32'(tap_mode), 32'(m == 5 || m == 1), "tap mode");
    end
    send_words();
    $display("test mode pins done");
    host.load_ir(`CSL_IR_CFG_LOAD);
    host.shift_dr({96'h0, `CSL_SYNC_WORD}, 32, rd);
    host.shift_dr(128'($urandom()), 16, rd);
    host.load_ir(`CSL_IR_READBACK);
    repeat (20) @(negedge clk);
    check(busy_cnt, `CSL_ABORT_CYCLES, "busy length");
    send_words();
    $display("test abort done");
    @(posedge clk);
    rb_data <= $urandom();
    host.load_ir(`CSL_IR_READBACK);
    host.shift_dr(128'h0, 32, rd);
    check(rd, 32'h0, "first readback");
    host.shift_dr(128'h0, 32, rd);
    check(rd, rb_data, "readback");
    check(32'(rb_reqs > 1), 32'h1, "requests");
    $display("test readback done");
    startup();
    check_ready();
    $display("test start-up done");
    o = '0;
    o.lock_wait = 1'b1;
    o.lock_mask = 8'($urandom_range(255, 1));
    run_held(o, o.lock_mask & (~o.lock_mask + 8'h01));
    $display("test lock wait done");
    o.lock_all = 1'b1;
    run_held(o, o.lock_mask);
    $display("test lock all done");
    o = '0;
    o.sync_done = 1'b1;
    run_held(o, 8'h00);
    $display("test shared done done");
    complete_run();
  end
endmodule : tb_top

bind csl_loader csl_loader_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .mode_select(mode_select), .restart_n(restart_n),
  .init_in(init_in), .init_oe(init_oe), .done_oe(done_oe), .dll_locked(dll_locked),
  .opts(opts), .cfg_word_valid(cfg_word_valid), .busy(busy), .done(done),
  .tap_mode(tap_mode), .globals(globals), .phase(phase));
